// [shared/pmc_consts.svh]
// Register offsets, field positions, reset values and timing counts
`ifndef PMC_CONSTS_SVH
`define PMC_CONSTS_SVH

`define PMC_CLK_MHZ          50
`define PMC_DEGLITCH_US      200
`define PMC_DEGLITCH_CYC     (`PMC_DEGLITCH_US * `PMC_CLK_MHZ)
`define PMC_LONG_UNIT_S      4
`define PMC_LONG_UNIT_CYC    (`PMC_LONG_UNIT_S * 1000000 * `PMC_CLK_MHZ)
`define PMC_MODE_QUAL_RST    16'h00fa
`define PMC_SETTLE_CYC       16

`define PMC_OFF_CTRL         12'h000
`define PMC_OFF_MODECFG      12'h004
`define PMC_IDX_PINSEL       8'h22
`define PMC_IDX_RSTMON       8'h71
`define PMC_OFF_PINSEL       12'(`PMC_IDX_PINSEL * 4)
`define PMC_OFF_QUAL         12'h00c
`define PMC_OFF_STATUS       12'h010
`define PMC_OFF_RSTMON       12'(`PMC_IDX_RSTMON * 4)

`define PMC_CTRL_REGMODE_LO  0
`define PMC_CTRL_REGMODE_HI  1
`define PMC_CTRL_LONGSEL_LO  2
`define PMC_CTRL_THERM_EN    4
`define PMC_CTRL_SHIP        5
`define PMC_CTRL_PWRDN       6
`define PMC_CTRL_RESET       32'h0000_0000
`define PMC_RSTMON_KEY       7
`endif

// [shared/pmc_pkg.sv]
// Types shared by the mode and reset control block
package pmc_pkg;
    typedef enum logic [2:0] {
        PMC_ST_STANDBY = 3'b000,
        PMC_ST_PWRUP   = 3'b001,
        PMC_ST_ACTIVE  = 3'b010,
        PMC_ST_ENABLE  = 3'b011,
        PMC_ST_DISABLE = 3'b100,
        PMC_ST_PWRDN   = 3'b101
    } pmc_state_e;
    typedef enum logic [1:0] {
        PMC_TZ_NORMAL = 2'b00,
        PMC_TZ_SUSPEND = 2'b01,
        PMC_TZ_HALF   = 2'b10,
        PMC_TZ_HOTCV  = 2'b11
    } pmc_tzone_e;
    typedef logic [1:0] pmc_mode_t;
    typedef logic [3:0] pmc_rails_t;
endpackage

// [verilog/pmc_sync.sv]
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module pmc_sync #(
    parameter int W = 1
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_q <= '0;
            dout   <= '0;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule

// [verilog/pmc_key_filter.sv]
// Power key deglitch, filtered falling edge and long-press detect
`timescale 1ns/1ps
`include "pmc_consts.svh"
module pmc_key_filter (
    // Clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // Synchronised key level and long-press select
    input  wire logic       key_sync,
    input  wire logic [1:0] long_press_time_sel,
    // Results
    output logic            key_level_q,
    output logic            key_fall_q,
    output logic            long_press_q
);
    logic [13:0] glt_q;
    logic [31:0] hold_q;
    wire  [31:0] long_lim = (32'({30'd0, long_press_time_sel}) + 32'd1) * `PMC_LONG_UNIT_CYC;
    wire         stable   = (glt_q == 14'(`PMC_DEGLITCH_CYC - 1));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            glt_q        <= '0;
            key_level_q  <= 1'b1;
            key_fall_q   <= 1'b0;
            hold_q       <= '0;
            long_press_q <= 1'b0;
        end else begin
            key_fall_q   <= 1'b0;
            long_press_q <= 1'b0;
            if (key_sync == key_level_q) begin
                glt_q <= '0;
            end else if (stable) begin
                glt_q       <= '0;
                key_level_q <= key_sync;
                key_fall_q  <= !key_sync;
            end else begin
                glt_q <= glt_q + 14'd1;
            end
            if (key_level_q) begin
                hold_q <= '0;
            end else if (hold_q == long_lim - 32'd1) begin
                hold_q       <= hold_q + 32'd1;
                long_press_q <= 1'b1;
            end else if (hold_q < long_lim) begin
                hold_q <= hold_q + 32'd1;
            end
        end
    end
endmodule

// [verilog/pmc_mode_reset_ctrl.sv]
// Operating mode, power key, system reset and thermistor zone control
`timescale 1ns/1ps
`include "pmc_consts.svh"

module pmc_mode_reset_ctrl
    import pmc_pkg::*;
(
    // Clock and reset
    input  wire logic         hclk,
    input  wire logic         hresetn,
    // AHB-Lite slave
    input  wire logic         hsel,
    input  wire logic [11:0]  haddr,
    input  wire logic [1:0]   htrans,
    input  wire logic         hwrite,
    input  wire logic [2:0]   hsize,
    input  wire logic [31:0]  hwdata,
    input  wire logic         hready,
    output logic [31:0]       hrdata,
    output logic              hreadyout,
    output logic              hresp,
    // Pins
    input  wire logic         power_key_n,
    input  wire logic         mode_pin_low_bit,
    input  wire logic         mode_pin_high_bit,
    output logic              system_reset_out_n_o,
    output logic              system_reset_out_n_oe,
    // Rail comparators, per rail: bit0 linear1, bit1 linear2, bit2 core, bit3 system
    input  wire pmc_rails_t   rail_under,
    input  wire pmc_rails_t   rail_over,
    // Thermistor zone comparators from sense input
    input  wire logic         therm_below_cold,
    input  wire logic         therm_below_cool,
    input  wire logic         therm_above_warm,
    input  wire logic         therm_above_hot,
    // Rail and charger control
    output pmc_rails_t        rail_enable,
    output pmc_mode_t         active_mode,
    output logic              volt_change,
    output logic              rail_default_reload,
    output logic              charge_suspend,
    output logic              charge_half_current,
    output logic              charge_cv_hot_offset
);
    import pmc_pkg::*;

    logic [31:0]  ctrl_q;
    logic [7:0]   mode_cfg_q [4];
    logic [15:0]  qual_q;
    pmc_state_e   state_q;
    pmc_mode_t    mode_q;
    pmc_mode_t    target_q;
    pmc_mode_t    pin_last_q;
    logic [15:0]  pin_cnt_q;
    logic [4:0]   settle_q;
    logic         ship_q;
    logic         move_q;
    logic         rst_out_q;
    logic         ahb_wr_q;
    logic [11:0]  ahb_addr_q;
    logic [31:0]  rdata_q;
    pmc_rails_t   rail_en_q;
    logic [2:0]   tz_q;
    logic [1:0]   pins_s;
    logic         key_s;
    logic         key_level;
    logic         key_fall;
    logic         long_press;

    // Mode config byte: [3:0] rail enables, [4] pin select, [5] key-to-mode0
    wire pmc_rails_t cur_rails  = mode_cfg_q[mode_q][3:0];
    wire pmc_rails_t tgt_rails  = mode_cfg_q[target_q][3:0];
    wire             pin_ctrl   = mode_cfg_q[mode_q][4];
    wire             key_mode0  = mode_cfg_q[mode_q][5];
    wire             in_seq     = (state_q == PMC_ST_PWRUP) || (state_q == PMC_ST_PWRDN);
    wire             key_ok     = key_fall && !in_seq;
    wire pmc_mode_t  reg_mode   = {ctrl_q[`PMC_CTRL_REGMODE_HI], ctrl_q[`PMC_CTRL_REGMODE_LO]};
    wire pmc_mode_t  pin_mode   = pins_s;
    wire             pin_stable = (pin_mode == pin_last_q) && (pin_cnt_q >= qual_q);
    wire pmc_mode_t  req_mode   = pin_ctrl ? pin_mode : reg_mode;
    wire             req_ok     = pin_ctrl ? pin_stable : 1'b1;
    wire             mode_req   = (state_q == PMC_ST_ACTIVE) && req_ok && (req_mode != mode_q);
    wire             new_up     = ~|(tgt_rails & ~cur_rails & rail_under);
    wire             all_up     = ~|(rail_en_q & rail_under);
    wire             rail_bad   = |(rail_en_q & (rail_under | rail_over));
    wire             settling   = (settle_q != 5'd0);

    // AHB decode
    wire        ahb_go   = hsel && hready && htrans[1];
    wire        sel_ctrl = (ahb_addr_q == `PMC_OFF_CTRL);
    wire        sel_qual = (ahb_addr_q == `PMC_OFF_QUAL);
    wire        sel_pins = (ahb_addr_q == `PMC_OFF_PINSEL);
    wire        sel_mcfg = (ahb_addr_q[11:4] == 8'h00) && (ahb_addr_q[3:0] == 4'h4);
    wire [31:0] rd_mux   =
        (haddr == `PMC_OFF_CTRL)    ? ctrl_q :
        (haddr == `PMC_OFF_MODECFG) ? {mode_cfg_q[3],mode_cfg_q[2],mode_cfg_q[1],mode_cfg_q[0]} :
        (haddr == `PMC_OFF_PINSEL)  ? {28'h0, mode_cfg_q[3][4], mode_cfg_q[2][4],
                                       mode_cfg_q[1][4], mode_cfg_q[0][4]} :
        (haddr == `PMC_OFF_QUAL)    ? {16'h0, qual_q} :
        (haddr == `PMC_OFF_STATUS)  ? {20'h0, 1'b0, state_q, target_q, mode_q,
                                       ship_q, move_q, rail_en_q[1:0]} :
        (haddr == `PMC_OFF_RSTMON)  ? {24'h0, key_level, 3'h0, rail_en_q} :
                                      32'h0;

    pmc_sync #(.W(3)) u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .din     ({mode_pin_high_bit, mode_pin_low_bit, power_key_n}),
        .dout    ({pins_s, key_s})
    );

    pmc_key_filter u_key (
        .hclk                (hclk),
        .hresetn             (hresetn),
        .key_sync            (key_s),
        .long_press_time_sel (ctrl_q[`PMC_CTRL_LONGSEL_LO+1:`PMC_CTRL_LONGSEL_LO]),
        .key_level_q         (key_level),
        .key_fall_q          (key_fall),
        .long_press_q        (long_press)
    );

    // Bus slave: zero wait states, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ahb_wr_q   <= 1'b0;
            ahb_addr_q <= '0;
            rdata_q    <= '0;
        end else begin
            ahb_wr_q   <= ahb_go && hwrite;
            ahb_addr_q <= haddr;
            rdata_q    <= (ahb_go && !hwrite) ? rd_mux : rdata_q;
        end
    end

    // Software registers; writes win over SHIP and PWRDN clears, other hardware clears win over writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= `PMC_CTRL_RESET;
            qual_q <= `PMC_MODE_QUAL_RST;
        end else begin
            if (ahb_wr_q && sel_ctrl) begin
                ctrl_q <= hwdata;
            end else begin
                ctrl_q[`PMC_CTRL_SHIP]  <= ctrl_q[`PMC_CTRL_SHIP] && !ship_q;
                ctrl_q[`PMC_CTRL_PWRDN] <= ctrl_q[`PMC_CTRL_PWRDN]
                                           && (state_q != PMC_ST_STANDBY);
            end
            if (long_press) begin
                ctrl_q[`PMC_CTRL_REGMODE_HI:`PMC_CTRL_REGMODE_LO] <= 2'b00;
            end else if (key_ok && key_mode0) begin
                ctrl_q[`PMC_CTRL_REGMODE_HI:`PMC_CTRL_REGMODE_LO] <= 2'b00;
            end
            if (ahb_wr_q && sel_qual) begin
                qual_q <= hwdata[15:0];
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_mcfg
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    mode_cfg_q[gi] <= 8'h0f;
                end else if (long_press) begin
                    mode_cfg_q[gi] <= 8'h0f;
                end else begin
                    if (ahb_wr_q && sel_mcfg) begin
                        mode_cfg_q[gi] <= hwdata[gi*8 +: 8];
                    end
                    if (ahb_wr_q && sel_pins) begin
                        mode_cfg_q[gi][4] <= hwdata[gi];
                    end
                    if (key_fall) begin
                        mode_cfg_q[gi][4] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // Pin pair stability counter
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_last_q <= 2'b00;
            pin_cnt_q  <= '0;
        end else if (pin_mode != pin_last_q) begin
            pin_last_q <= pin_mode;
            pin_cnt_q  <= '0;
        end else if (pin_cnt_q != 16'hffff) begin
            pin_cnt_q  <= pin_cnt_q + 16'd1;
        end
    end

    // Sequencer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q   <= PMC_ST_STANDBY;
            mode_q    <= 2'b00;
            target_q  <= 2'b00;
            rail_en_q <= '0;
            ship_q    <= 1'b0;
            move_q    <= 1'b0;
            settle_q  <= '0;
        end else begin
            settle_q <= settling ? settle_q - 5'd1 : settle_q;
            move_q   <= settling || (move_q && mode_req);
            if (ctrl_q[`PMC_CTRL_SHIP] && state_q == PMC_ST_STANDBY) begin
                ship_q <= 1'b1;
            end
            if (long_press) begin
                state_q   <= PMC_ST_PWRUP;
                mode_q    <= 2'b00;
                target_q  <= 2'b00;
                rail_en_q <= '0;
                ship_q    <= 1'b0;
            end else begin
                case (state_q)
                    PMC_ST_STANDBY: begin
                        if (key_ok) begin
                            state_q  <= PMC_ST_PWRUP;
                            ship_q   <= 1'b0;
                            mode_q   <= ship_q ? 2'b00 : mode_q;
                            target_q <= ship_q ? 2'b00 : mode_q;
                        end
                    end
                    PMC_ST_PWRUP: begin
                        rail_en_q <= cur_rails;
                        if (rail_en_q == cur_rails && all_up) begin
                            state_q <= PMC_ST_ACTIVE;
                        end
                    end
                    PMC_ST_ACTIVE: begin
                        if (ctrl_q[`PMC_CTRL_SHIP] || ctrl_q[`PMC_CTRL_PWRDN]) begin
                            state_q <= PMC_ST_PWRDN;
                        end else if (key_ok && key_mode0 && mode_q != 2'b00) begin
                            target_q <= 2'b00;
                            state_q  <= PMC_ST_ENABLE;
                            settle_q <= 5'(`PMC_SETTLE_CYC);
                        end else if (mode_req) begin
                            target_q <= req_mode;
                            state_q  <= PMC_ST_ENABLE;
                            settle_q <= 5'(`PMC_SETTLE_CYC);
                        end
                    end
                    PMC_ST_ENABLE: begin
                        rail_en_q <= cur_rails | tgt_rails;
                        if (new_up && rail_en_q == (cur_rails | tgt_rails)) begin
                            state_q <= PMC_ST_DISABLE;
                        end
                    end
                    PMC_ST_DISABLE: begin
                        rail_en_q <= tgt_rails;
                        mode_q    <= target_q;
                        state_q   <= PMC_ST_ACTIVE;
                    end
                    PMC_ST_PWRDN: begin
                        rail_en_q <= '0;
                        state_q   <= PMC_ST_STANDBY;
                    end
                    default: state_q <= PMC_ST_STANDBY;
                endcase
            end
        end
    end

    // Reset output and thermistor zone
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rst_out_q <= 1'b1;
            tz_q      <= '0;
        end else begin
            if (in_seq || state_q == PMC_ST_STANDBY) begin
                rst_out_q <= 1'b1;
            end else if (move_q || settling) begin
                rst_out_q <= 1'b0;
            end else begin
                rst_out_q <= rail_bad;
            end
            tz_q[0] <= ctrl_q[`PMC_CTRL_THERM_EN] && (therm_below_cold || therm_above_hot);
            tz_q[1] <= ctrl_q[`PMC_CTRL_THERM_EN] && !therm_below_cold && therm_below_cool;
            tz_q[2] <= ctrl_q[`PMC_CTRL_THERM_EN] && therm_above_warm && !therm_above_hot;
        end
    end

    assign hrdata                = rdata_q;
    assign hreadyout             = 1'b1;
    assign hresp                 = 1'b0;
    assign system_reset_out_n_o  = 1'b0;
    assign system_reset_out_n_oe = rst_out_q;
    assign rail_enable           = rail_en_q;
    assign active_mode           = mode_q;
    assign volt_change           = move_q;
    assign rail_default_reload   = long_press;
    assign charge_suspend        = tz_q[0];
    assign charge_half_current   = tz_q[1];
    assign charge_cv_hot_offset  = tz_q[2];
endmodule

// [test/pmc_mode_reset_ctrl_sva.sv]
// Concurrent checks on the mode and reset control ports
`timescale 1ns/1ps
module pmc_mode_reset_ctrl_sva (
    // Clock and reset
    input wire logic                hclk,
    input wire logic                hresetn,
    // Bus answer
    input wire logic                hreadyout,
    input wire logic                hresp,
    // Reset pin
    input wire logic                system_reset_out_n_o,
    input wire logic                system_reset_out_n_oe,
    // Rails and mode
    input wire pmc_pkg::pmc_rails_t rail_under,
    input wire pmc_pkg::pmc_rails_t rail_over,
    input wire pmc_pkg::pmc_rails_t rail_enable,
    input wire pmc_pkg::pmc_mode_t  active_mode,
    input wire logic                volt_change,
    // Thermistor zones and charger controls
    input wire logic                therm_below_cold,
    input wire logic                therm_below_cool,
    input wire logic                therm_above_warm,
    input wire logic                therm_above_hot,
    input wire logic                charge_suspend,
    input wire logic                charge_half_current,
    input wire logic                charge_cv_hot_offset
);
    import pmc_pkg::*;
    pmc_rails_t bad_rails;
    // Only enabled rails count as out of window
    assign bad_rails = (rail_under | rail_over) & rail_enable;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus slave not ready or not okay");
    a_pin_pulls_low: assert property (system_reset_out_n_o == 1'b0)
        else $error("reset pin drives a high level");
    a_mode_after_reset: assert property ($rose(hresetn) |-> active_mode == 2'b00)
        else $error("mode not zero after reset");
    a_rst_bad_rail: assert property ((bad_rails != 4'h0 && !volt_change) [*4]
        |-> system_reset_out_n_oe)
        else $error("reset not asserted for bad enabled rail");
    a_rst_release: assert property ((bad_rails == 4'h0 && rail_enable != 4'h0 && !volt_change) [*6]
        |-> !system_reset_out_n_oe)
        else $error("reset held with all enabled rails good");
    a_no_rst_moving: assert property (volt_change && $past(volt_change)
        |-> !$rose(system_reset_out_n_oe))
        else $error("reset asserted during voltage move");
    a_suspend_zone: assert property (charge_suspend
        |-> $past(therm_below_cold || therm_above_hot))
        else $error("charge suspended outside cold or hot zone");
    a_half_zone: assert property (charge_half_current
        |-> $past(therm_below_cool) && !$past(therm_below_cold))
        else $error("half current outside cool zone");
    a_hot_offset_zone: assert property (charge_cv_hot_offset
        |-> $past(therm_above_warm) && !$past(therm_above_hot))
        else $error("hot offset outside warm zone");
    c_reset_pulse: cover property ($rose(system_reset_out_n_oe));
    c_mode_change: cover property ($changed(active_mode));
    c_half: cover property (charge_half_current);
endmodule

bind pmc_mode_reset_ctrl pmc_mode_reset_ctrl_sva u_sva (
    .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
    .system_reset_out_n_o(system_reset_out_n_o), .system_reset_out_n_oe(system_reset_out_n_oe),
    .rail_under(rail_under), .rail_over(rail_over), .rail_enable(rail_enable),
    .active_mode(active_mode), .volt_change(volt_change),
    .therm_below_cold(therm_below_cold), .therm_below_cool(therm_below_cool),
    .therm_above_warm(therm_above_warm), .therm_above_hot(therm_above_hot),
    .charge_suspend(charge_suspend), .charge_half_current(charge_half_current),
    .charge_cv_hot_offset(charge_cv_hot_offset)
);

// [test/pmc_host_model.sv]
// Host controller model: drives the mode pins, sees the reset line
`timescale 1ns/1ps
module pmc_host_model #(
    parameter int HOLD = 260,
    parameter int SKEW = 10
) (
    // Clock and requested mode
    input  wire logic       hclk,
    input  wire logic [1:0] want_mode,
    // Reset line from the device
    input  wire logic       rst_o,
    input  wire logic       rst_oe,
    // Pins and status
    output logic            mode_pin_low_bit,
    output logic            mode_pin_high_bit,
    output logic            sys_reset_n,
    output logic            idle
);
    int   hold_q;
    logic step_q;
    // Open-drain line with pull-up
    assign sys_reset_n = rst_oe ? rst_o : 1'b1;
    assign idle = (hold_q == 0) && !step_q && (want_mode == {mode_pin_high_bit, mode_pin_low_bit});
    initial begin
        mode_pin_low_bit = 1'b0;
        mode_pin_high_bit = 1'b0;
        hold_q = 0;
        step_q = 1'b0;
    end
    always @(posedge hclk) begin
        if (hold_q != 0) begin
            hold_q <= hold_q - 1;
        end else if (step_q) begin
            mode_pin_high_bit <= want_mode[1];
            step_q <= 1'b0;
            hold_q <= HOLD;
        end else if (want_mode != {mode_pin_high_bit, mode_pin_low_bit}) begin
            mode_pin_low_bit <= want_mode[0];
            step_q <= 1'b1;
            hold_q <= SKEW;
        end
    end
endmodule

// [test/pmc_mode_reset_ctrl_tb_top.sv]
// Self-checking bench for the mode and reset control block
`timescale 1ns/1ps
`include "pmc_consts.svh"
module pmc_mode_reset_ctrl_tb_top;
    import pmc_pkg::*;
    typedef struct packed {
        logic [3:0] zone;
        logic [2:0] expv;
    } pmc_row_s;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [11:0] haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, rd;
    wire         hready;
    logic        power_key_n, mode_lo, mode_hi, rst_o, rst_oe, sys_reset_n, host_idle;
    logic [1:0]  want_mode;
    pmc_rails_t  rail_under, rail_over, rail_enable;
    logic [3:0]  zone;
    pmc_mode_t   active_mode;
    logic        volt_change, reload, suspend, half, hot, vc_seen;
    int          mismatches, samples_checked;
    pmc_row_s    rows[5];
    assign hready = hreadyout;
    pmc_mode_reset_ctrl uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .power_key_n(power_key_n),
        .mode_pin_low_bit(mode_lo), .mode_pin_high_bit(mode_hi),
        .system_reset_out_n_o(rst_o), .system_reset_out_n_oe(rst_oe),
        .rail_under(rail_under), .rail_over(rail_over),
        .therm_below_cold(zone[3]), .therm_below_cool(zone[2]),
        .therm_above_warm(zone[1]), .therm_above_hot(zone[0]),
        .rail_enable(rail_enable), .active_mode(active_mode), .volt_change(volt_change),
        .rail_default_reload(reload), .charge_suspend(suspend),
        .charge_half_current(half), .charge_cv_hot_offset(hot)
    );
    pmc_host_model u_host (
        .hclk(hclk), .want_mode(want_mode), .rst_o(rst_o), .rst_oe(rst_oe),
        .mode_pin_low_bit(mode_lo), .mode_pin_high_bit(mode_hi),
        .sys_reset_n(sys_reset_n), .idle(host_idle)
    );
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        if (volt_change === 1'b1) vc_seen <= 1'b1;
    end
    task automatic final_report();
        $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] expv);
        samples_checked++;
        if (got !== expv) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, expv);
        end
    endtask
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 64);
        if (hready !== 1'b1) begin
            mismatches++;
            final_report();
        end
    endtask
    // One single word transfer; read data lands in rd
    task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        hsize <= 3'b010;
        wait_rdy();
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask
    task automatic wait_out(input pmc_mode_t m, input pmc_rails_t r, input int lim);
        int n;
        n = 0;
        while ((active_mode !== m || rail_enable !== r) && n < lim) begin
            @(posedge hclk);
            n++;
        end
        chk({28'h0, rail_enable}, {28'h0, r});
        chk({30'h0, active_mode}, {30'h0, m});
        if (n >= lim) final_report();
    endtask
    task automatic wait_host();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (host_idle !== 1'b1 && n < 1000);
        chk({31'h0, host_idle}, 32'h1);
        if (n >= 1000) final_report();
    endtask
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 12'h000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        power_key_n = 1'b1;
        want_mode = 2'b00;
        rail_under = 4'h0;
        rail_over = 4'h0;
        zone = 4'h0;
        vc_seen = 1'b0;
        mismatches = 0;
        samples_checked = 0;
        // Zone inputs {cold, cool, warm, hot} against {suspend, half, hot offset}
        rows[0] = {4'b0000, 3'b000};
        rows[1] = {4'b1100, 3'b100};
        rows[2] = {4'b0100, 3'b010};
        rows[3] = {4'b0010, 3'b001};
        rows[4] = {4'b0011, 3'b100};
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk({26'h0, active_mode, rail_enable}, 32'h0);
        bus(`PMC_OFF_CTRL, 1'b0, 32'h0);
        chk(rd, `PMC_CTRL_RESET);
        bus(`PMC_OFF_MODECFG, 1'b0, 32'h0);
        chk(rd, 32'h0f0f_0f0f);
        bus(`PMC_OFF_QUAL, 1'b0, 32'h0);
        chk(rd, {16'h0, `PMC_MODE_QUAL_RST});
        bus(12'h100, 1'b1, 32'hffff_ffff);
        bus(12'h100, 1'b0, 32'h0);
        chk(rd, 32'h0);
        // Power up from standby on a held key
        power_key_n <= 1'b0;
        wait_out(2'd0, 4'hf, 12000);
        bus(`PMC_OFF_RSTMON, 1'b0, 32'h0);
        chk(rd & 32'h8f, 32'h0f);
        power_key_n <= 1'b1;
        repeat (10100) @(posedge hclk);
        bus(`PMC_OFF_RSTMON, 1'b0, 32'h0);
        chk(rd & 32'h80, 32'h80);
        // Modes 1 and 2 pin controlled, mode 2 returns on key
        bus(`PMC_OFF_QUAL, 1'b1, 32'h20);
        bus(`PMC_OFF_MODECFG, 1'b1, 32'h0f3c_130f);
        want_mode <= 2'd3;
        wait_host();
        repeat (100) @(posedge hclk);
        chk({30'h0, active_mode}, 32'h0);
        want_mode <= 2'd1;
        wait_host();
        bus(`PMC_OFF_CTRL, 1'b1, 32'h1);
        wait_out(2'd1, 4'h3, 500);
        chk({31'h0, vc_seen}, 32'h1);
        bus(`PMC_OFF_CTRL, 1'b1, 32'h3);
        repeat (100) @(posedge hclk);
        chk({30'h0, active_mode}, 32'h1);
        want_mode <= 2'd2;
        wait_out(2'd2, 4'hc, 1000);
        // Reset pin against enabled and disabled rails
        rail_under <= 4'h3;
        repeat (20) @(posedge hclk);
        chk({31'h0, rst_oe}, 32'h0);
        rail_under <= 4'h4;
        repeat (10) @(posedge hclk);
        chk({30'h0, rst_oe, sys_reset_n}, 32'h2);
        rail_under <= 4'h0;
        rail_over <= 4'h8;
        repeat (10) @(posedge hclk);
        chk({31'h0, rst_oe}, 32'h1);
        rail_over <= 4'h0;
        repeat (10) @(posedge hclk);
        chk({31'h0, rst_oe}, 32'h0);
        // Key edge returns to mode 0 and clears pin control
        power_key_n <= 1'b0;
        wait_out(2'd0, 4'hf, 12000);
        bus(`PMC_OFF_PINSEL, 1'b0, 32'h0);
        chk(rd & 32'hf, 32'h0);
        power_key_n <= 1'b1;
        repeat (10100) @(posedge hclk);
        // Thermistor zones with monitoring on, then off
        bus(`PMC_OFF_CTRL, 1'b1, 32'h10);
        foreach (rows[i]) begin
            zone <= rows[i].zone;
            repeat (3) @(posedge hclk);
            chk({29'h0, suspend, half, hot}, {29'h0, rows[i].expv});
        end
        bus(`PMC_OFF_CTRL, 1'b1, 32'h0);
        zone <= 4'b1100;
        repeat (3) @(posedge hclk);
        chk({29'h0, suspend, half, hot}, 32'h0);
        bus(`PMC_OFF_CTRL, 1'b1, 32'h1);
        wait_out(2'd1, 4'h3, 500);
        repeat (20) @(posedge hclk);
        bus(`PMC_OFF_CTRL, 1'b1, 32'h21);
        power_key_n <= 1'b0;
        wait_out(2'd0, 4'hf, 12000);
        final_report();
    end
endmodule
